// ===== shared/feac_cfg.svh
`ifndef FEAC_CFG_SVH
`define FEAC_CFG_SVH
// apb register byte offsets
`define FEAC_CTRL_OFS      12'h000
`define FEAC_CBIT_OFS      12'h004
`define FEAC_TRIG_OFS      12'h008
`define FEAC_STAT_OFS      12'h00c
// control register fields
`define CTRL_ALARM_LSB     0
`define CTRL_LINE_LSB      8
`define CTRL_SIZE_LSB      16
`define CTRL_SEL_LSB       20
`define CTRL_CONT_BIT      22
// reset values
`define CTRL_RST           23'h030000
`define CBIT_RST           21'h1fffff
// c-bit index of the feac bit (row 1, c3)
`define FEAC_CBIT_IDX      2
// line id codes
`define LINE_DS3           6'h1b
`define LINE_DS1_BASE      6'h20
`define LINE_DS1_ALL       6'h13
// alarm and status codes
`define CODE_DS3_EQ_SA     6'h19
`define CODE_DS3_LOS       6'h0e
`define CODE_DS3_OOF       6'h00
`define CODE_DS3_AIS       6'h16
`define CODE_DS3_IDLE      6'h1a
`define CODE_DS3_EQ_NSA    6'h0f
`define CODE_COM_EQ_NSA    6'h1d
`define CODE_MULTI_DS1_LOS 6'h15
`define CODE_DS1_EQ_SA     6'h05
`define CODE_DS1_LOS       6'h1e
`define CODE_DS1_EQ_NSA    6'h03
`define CODE_LOOP_UP       6'h09
`define CODE_LOOP_DOWN     6'h12
// codeword framing
`define WORD_BITS          16
`define WORD_LAST          4'hf
`define BURST_MIN          4'h3
`endif

// ===== shared/feac_pkg.sv
package feac_pkg;
   typedef enum logic [1:0]
   {
      SEL_NONE  = 2'b00,
      SEL_UP    = 2'b01,
      SEL_DOWN  = 2'b10,
      SEL_ALARM = 2'b11
   } burst_sel_e;
   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_CONT  = 2'b01,
      ST_BURST = 2'b10
   } send_state_e;
endpackage : feac_pkg

// ===== core/feac_serializer.sv
`include "feac_cfg.svh"
// shifts one 16-bit codeword out, one bit per m-frame strobe
module feac_serializer
   import feac_pkg::*;
(
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // word load
   input  wire logic       load,
   input  wire logic [5:0] code,
   input  wire logic       frame_tick,
   // output
   output logic            bit_out,
   output logic            busy,
   output logic            word_done
);
   typedef struct packed
   {
      logic [15:0] sh;
      logic [3:0]  cnt;
      logic        busy;
      logic        out;
      logic        done;
   } ser_s;
   ser_s st_ff;
   ser_s nxt_st;

   // word: 0, code msb first, 0, eight ones
   always_comb
   begin
      nxt_st      = st_ff;
      nxt_st.done = 1'b0;
      if (load && !st_ff.busy)
      begin
         nxt_st.sh   = {1'b0, code, 1'b0, 8'hff};
         nxt_st.cnt  = 4'h0;
         nxt_st.busy = 1'b1;
         nxt_st.out  = 1'b1; // line rests high until the first strobe
      end
      else if (st_ff.busy && frame_tick)
      begin
         nxt_st.out = st_ff.sh[`WORD_BITS-1];
         nxt_st.sh  = {st_ff.sh[14:0], 1'b1};
         nxt_st.cnt = st_ff.cnt + 4'h1;
         if (st_ff.cnt == `WORD_LAST)
         begin
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign bit_out   = st_ff.out;
   assign busy      = st_ff.busy;
   assign word_done = st_ff.done;
endmodule : feac_serializer

// ===== core/ds3_feac_code_sender.sv
// Our own choices: the APB slave port and the register addresses.
`include "feac_cfg.svh"
module ds3_feac_code_sender
   import feac_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // ds3 framing
   input  wire logic        mframe_tick,
   // c-bit outputs, index = (row-1)*3 + (cbit-1)
   output logic [20:0]      cbit_out,
   output logic             feac_active
);
   typedef struct packed
   {
      logic [22:0]  ctrl;
      logic [20:0]  cbits;
      send_state_e  state;
      logic [3:0]   left;
      logic [5:0]   code;
      logic         load;
      logic         trig;
      logic [31:0]  rdata;
      logic         ready;
      logic         err;
      logic [20:0]  cout;
      logic         active;
   } top_s;
   top_s st_ff;
   top_s nxt_st;

   logic ser_bit;
   logic ser_busy;
   logic ser_done;

   // alarm field accepted only for listed codes; others keep old value
   function automatic logic code_known(input logic [5:0] c);
      case (c)
         `CODE_DS3_EQ_SA, `CODE_DS3_LOS, `CODE_DS3_OOF, `CODE_DS3_AIS,
         `CODE_DS3_IDLE, `CODE_DS3_EQ_NSA,
         `CODE_COM_EQ_NSA, `CODE_MULTI_DS1_LOS, `CODE_DS1_EQ_SA,
         `CODE_DS1_LOS, `CODE_DS1_EQ_NSA,
         `CODE_LOOP_UP, `CODE_LOOP_DOWN: code_known = 1'b1;
         default: code_known = 1'b0;
      endcase
   endfunction : code_known

   // line address: ds3, ds1 1..28, or all ds1
   function automatic logic line_known(input logic [5:0] l);
      line_known = (l == `LINE_DS3) || (l == `LINE_DS1_ALL) ||
                   (l > `LINE_DS1_BASE && l <= (`LINE_DS1_BASE + 6'h1c));
   endfunction : line_known

   wire logic [5:0]  f_alarm = st_ff.ctrl[`CTRL_ALARM_LSB +: 6];
   wire logic [5:0]  f_line  = st_ff.ctrl[`CTRL_LINE_LSB +: 6];
   wire logic [3:0]  f_size  = st_ff.ctrl[`CTRL_SIZE_LSB +: 4];
   wire logic [1:0]  f_sel   = st_ff.ctrl[`CTRL_SEL_LSB +: 2];
   wire logic        f_cont  = st_ff.ctrl[`CTRL_CONT_BIT];

   // apb decode, registers and sending state
   always_comb
   begin
      logic        wr;
      logic        rd;
      logic [5:0]  wa;
      logic [5:0]  wl;
      logic [3:0]  ws;
      wr            = psel && penable && pwrite && !st_ff.ready;
      rd            = psel && penable && !pwrite && !st_ff.ready;
      wa            = pwdata[`CTRL_ALARM_LSB +: 6];
      wl            = pwdata[`CTRL_LINE_LSB +: 6];
      ws            = pwdata[`CTRL_SIZE_LSB +: 4];
      nxt_st        = st_ff;
      nxt_st.ready  = psel && penable && !st_ff.ready;
      nxt_st.err    = 1'b0;
      nxt_st.rdata  = 32'h0;
      nxt_st.load   = 1'b0;
      nxt_st.trig   = 1'b0;
      if (wr)
      begin
         unique case (paddr)
            `FEAC_CTRL_OFS:
            begin
               nxt_st.ctrl[`CTRL_SEL_LSB +: 2] = pwdata[`CTRL_SEL_LSB +: 2];
               nxt_st.ctrl[`CTRL_CONT_BIT]      = pwdata[`CTRL_CONT_BIT];
               if (code_known(wa))
                  nxt_st.ctrl[`CTRL_ALARM_LSB +: 6] = wa;
               if (line_known(wl))
                  nxt_st.ctrl[`CTRL_LINE_LSB +: 6] = wl;
               if (ws >= `BURST_MIN)
                  nxt_st.ctrl[`CTRL_SIZE_LSB +: 4] = ws;
            end
            `FEAC_CBIT_OFS: nxt_st.cbits = pwdata[20:0];
            `FEAC_TRIG_OFS: nxt_st.trig  = pwdata[0];
            `FEAC_STAT_OFS: nxt_st.err   = 1'b1;
            default:        nxt_st.err   = 1'b1;
         endcase
      end
      if (rd)
      begin
         unique case (paddr)
            `FEAC_CTRL_OFS: nxt_st.rdata = {9'h0, st_ff.ctrl};
            `FEAC_CBIT_OFS: nxt_st.rdata = {11'h0, st_ff.cbits};
            `FEAC_TRIG_OFS: nxt_st.rdata = 32'h0;
            `FEAC_STAT_OFS: nxt_st.rdata = {22'h0, st_ff.code, st_ff.left[1:0], st_ff.state};
            default:        nxt_st.err   = 1'b1;
         endcase
      end

      unique case (st_ff.state)
         ST_IDLE:
         begin
            if (st_ff.trig && f_sel != SEL_NONE)
            begin
               nxt_st.state = ST_BURST;
               nxt_st.left  = f_size;
               unique case (f_sel)
                  SEL_UP:    nxt_st.code = f_line;
                  SEL_DOWN:  nxt_st.code = f_line;
                  SEL_ALARM: nxt_st.code = f_alarm;
                  default:   nxt_st.code = f_alarm;
               endcase
               nxt_st.code = (f_sel == SEL_UP) ? `CODE_LOOP_UP :
                             (f_sel == SEL_DOWN) ? `CODE_LOOP_DOWN : f_alarm;
            end
            else if (f_cont)
            begin
               nxt_st.state = ST_CONT;
               nxt_st.code  = f_alarm;
            end
         end
         ST_CONT:
         begin
            // no reload once the switch is off, but a load registered the cycle before the stop still sends one word
            nxt_st.load = f_cont && !ser_busy;
            if (!f_cont && !ser_busy)
               nxt_st.state = ST_IDLE;
         end
         ST_BURST:
         begin
            // done rises as busy falls; wait for the count to drop first
            nxt_st.load = !ser_busy && !ser_done && st_ff.left != 4'h0;
            if (ser_done)
            begin
               nxt_st.left = st_ff.left - 4'h1;
               if (st_ff.left == 4'h1)
                  nxt_st.state = ST_IDLE;
            end
         end
         default: nxt_st.state = ST_IDLE;
      endcase

      nxt_st.cout = st_ff.cbits;
      if (ser_busy)
         nxt_st.cout[`FEAC_CBIT_IDX] = ser_bit;
      nxt_st.active = st_ff.state != ST_IDLE;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff       <= '0;
         st_ff.ctrl  <= `CTRL_RST;
         st_ff.cbits <= `CBIT_RST;
         st_ff.cout  <= `CBIT_RST;
      end
      else
         st_ff <= nxt_st;
   end

   // codeword shifter; loop words carry the loop-up or loop-down code as the six code bits, not the line id
   feac_serializer u_ser
   (
      .pclk       (pclk),
      .presetn    (presetn),
      .load       (st_ff.load),
      .code       (st_ff.code),
      .frame_tick (mframe_tick),
      .bit_out    (ser_bit),
      .busy       (ser_busy),
      .word_done  (ser_done)
   );

   assign prdata      = st_ff.rdata;
   assign pready      = st_ff.ready;
   assign pslverr     = st_ff.err;
   assign cbit_out    = st_ff.cout;
   assign feac_active = st_ff.active;
endmodule : ds3_feac_code_sender

// ===== testbench/feac_monitor.sv
module feac_monitor
(
   // apb side
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // line side
   input wire logic        mframe_tick,
   input wire logic [20:0] cbit_out,
   input wire logic        feac_active
);
   logic [20:0] shadow_ff;
   logic        done;
   assign done = pready && psel && pwrite;
   // copy of the last c-bit write, so pins can be held against it
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         shadow_ff <= 21'h1fffff;
      else if (done && paddr == 12'h004)
         shadow_ff <= pwdata[20:0];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("answer not one cycle into access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_bad: assert property (pready && (paddr > 12'h00c || pwrite && paddr == 12'h00c) |-> pslverr)
      else $error("bad access not refused");
   a_trig_zero: assert property (pready && !pwrite && paddr == 12'h008 |-> prdata == 32'h0)
      else $error("trigger reads nonzero");
   a_cbit_follow: assert property (done && paddr == 12'h004 |-> ##2
      {cbit_out[20:3], cbit_out[1:0]} == {shadow_ff[20:3], shadow_ff[1:0]})
      else $error("c-bits do not follow write");
   a_cont_start: assert property (done && paddr == 12'h000 && pwdata[22] |-> ##[1:4] feac_active)
      else $error("continuous send not started");
   // the feac bit may only move on a frame strobe or a settings write
   a_bit_moves: assert property ($changed(cbit_out[2]) |->
      $past(mframe_tick) || $past(mframe_tick, 2) || $past(done) || $past(done, 2))
      else $error("feac bit moved off frame");
   a_rst_vals: assert property ($rose(presetn) |-> cbit_out == 21'h1fffff && !feac_active)
      else $error("bad values after reset");
   cover property (done && paddr == 12'h008);
   cover property ($fell(feac_active));
   cover property (pready && pslverr);
endmodule : feac_monitor

bind ds3_feac_code_sender feac_monitor i_feac_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .mframe_tick(mframe_tick), .cbit_out(cbit_out), .feac_active(feac_active));

// ===== testbench/feac_far_end.sv
module feac_far_end
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // framing pace and received channel
   input  wire logic [4:0]  gap,
   input  wire logic [20:0] cbit_out,
   output logic             mframe_tick,
   output int               words,
   output logic [5:0]       last_code
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0]  cnt_ff;
   logic [15:0] sh_ff;
   logic [15:0] nxt_sh;
   assign nxt_sh = {sh_ff[14:0], cbit_out[2]};
   // bit is taken at the next strobe, long after it settled
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cnt_ff <= 5'h00;
         mframe_tick <= 1'b0;
         sh_ff <= 16'hffff;
         words <= 0;
         last_code <= 6'h00;
      end
      else
      begin
         mframe_tick <= (cnt_ff >= gap);
         cnt_ff <= (cnt_ff >= gap) ? 5'h00 : cnt_ff + 5'h01;
         if (mframe_tick)
            sh_ff <= nxt_sh;
         // only the trailing ones give eight in a row, so no false lock
         if (mframe_tick && !nxt_sh[15] && !nxt_sh[8] && nxt_sh[7:0] == 8'hff)
         begin
            words <= words + 1;
            last_code <= nxt_sh[14:9];
         end
      end
endmodule : feac_far_end

// ===== testbench/ds3_feac_code_sender_bench.sv
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected %s exp %0h got %0h", n, e, g); end end
module ds3_feac_code_sender_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, mframe_tick, feac_active;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [20:0] cbit_out;
   logic [4:0]  gap;
   logic [5:0]  last_code, code, line;
   logic [3:0]  size;
   logic [1:0]  sel;
   int          words, w0, n_errors, total_checks;
   logic [5:0]  codes [13] = '{6'h19, 6'h0e, 6'h00, 6'h16, 6'h1a, 6'h0f, 6'h1d,
                               6'h15, 6'h05, 6'h1e, 6'h03, 6'h09, 6'h12};
   ds3_feac_code_sender i_ds3_feac_code_sender (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mframe_tick(mframe_tick), .cbit_out(cbit_out),
      .feac_active(feac_active));
   feac_far_end i_feac_far_end (.pclk(pclk), .presetn(presetn), .gap(gap), .cbit_out(cbit_out),
      .mframe_tick(mframe_tick), .words(words), .last_code(last_code));
   function automatic logic [5:0] expect_code(input logic [1:0] s, input logic [5:0] a);
      return (s == 2'h1) ? 6'h09 : (s == 2'h2) ? 6'h12 : a;
   endfunction : expect_code
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         n_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic settle(input int cap);
      int n;
      n = 0;
      while (feac_active !== 1'b0 && n < cap)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= cap)
         n_errors++;
      repeat (2 * gap + 8) @(posedge pclk);
   endtask : settle
   task complete_run;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial
   begin
      repeat (100000) @(posedge pclk);
      n_errors++;
      complete_run();
   end
   initial
   begin
      {psel, penable, pwrite, presetn, paddr, pwdata} = '0;
      gap = 5'h04;
      n_errors = 0;
      total_checks = 0;
      void'($urandom(97));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctrl reset", 32'h030000, rd)
      apb(1'b0, 12'h010, 32'h0);
      `CHK("unmapped err", 1'b1, err)
      apb(1'b1, 12'h00c, 32'h0);
      `CHK("stat write err", 1'b1, err)
      w0 = $urandom;
      apb(1'b1, 12'h004, w0);
      repeat (3) @(posedge pclk);
      `CHK("cbit pins", w0[20:0], cbit_out)
      apb(1'b1, 12'h004, 32'h1fffff);
      // each loop sel, boundary sizes first, retrigger mid-burst
      for (int k = 0; k < 10; k++)
      begin
         sel = (k == 9) ? 2'h0 : 2'(k % 3 + 1);
         size = (k == 0) ? 4'h3 : (k == 1) ? 4'hf : 4'(3 + $urandom % 13);
         code = codes[$urandom % 13];
         w0 = $urandom % 30;
         line = (w0 == 0) ? 6'h1b : (w0 == 1) ? 6'h13 : 6'(6'h1f + w0);
         gap <= 5'(3 + $urandom % 18);
         apb(1'b1, 12'h000, {10'h0, sel, size, 2'h0, line, 2'h0, code});
         apb(1'b0, 12'h000, 32'h0);
         `CHK("line held", line, rd[13:8])
         w0 = words;
         apb(1'b1, 12'h008, 32'h1);
         repeat (40) @(posedge pclk);
         apb(1'b1, 12'h008, 32'h1);
         settle(9000);
         `CHK("words sent", (sel == 2'h0) ? 0 : int'(size), words - w0)
         if (sel != 2'h0)
            `CHK("code sent", expect_code(sel, code), last_code)
      end
      gap <= 5'h03;
      code = codes[$urandom % 13];
      apb(1'b1, 12'h000, {9'h0, 1'b1, 2'h0, 4'h3, 10'h0, code});
      w0 = words;
      repeat (300) @(posedge pclk);
      apb(1'b0, 12'h00c, 32'h0);
      `CHK("state", 2'h1, rd[1:0])
      `CHK("cont code", code, last_code)
      `CHK("cont runs", 1'b1, (words - w0) >= 3)
      apb(1'b1, 12'h000, 32'h030000);
      settle(200);
      `CHK("cont stop", 1'b0, feac_active)
      complete_run();
   end
endmodule : ds3_feac_code_sender_bench
